// ==== hw/apsq_pkg.sv ====
// package of constants and types for the sleep-state power sequencer
`default_nettype none
package apsq_pkg;
  // clock figures
  localparam int unsigned CLK_HZ         = 20_000_000;
  localparam int unsigned CLK_NS         = 50;
  // glitch window, nominal 2 us
  localparam int unsigned GLITCH_NS      = 2_000;
  localparam int unsigned GLITCH_CYC     = GLITCH_NS / CLK_NS;
  // sleep entry delay 200 us
  localparam int unsigned SLEEP_DLY_NS   = 200_000;
  localparam int unsigned SLEEP_DLY_CYC  = SLEEP_DLY_NS / CLK_NS;
  // wake timeout 50 ms
  localparam int unsigned WAKE_MS        = 50;
  localparam int unsigned WAKE_CYC       = WAKE_MS * (CLK_HZ / 1000);
  // vid power-good delay, plain default
  localparam int unsigned VID_RAIL_GOOD_NS      = 1_000_000;
  localparam int unsigned VID_RAIL_GOOD_CYC     = VID_RAIL_GOOD_NS / CLK_NS;
  // short pause after standby power-on reset before soft-start
  localparam int unsigned POR_DLY_NS     = 10_000;
  localparam int unsigned POR_DLY_CYC    = POR_DLY_NS / CLK_NS;
  // counter widths
  localparam int unsigned CNT_W          = 24;
  // register map (axi4-lite byte offsets)
  localparam logic [7:0]  REG_CTRL       = 8'h00;
  localparam logic [7:0]  REG_STATUS     = 8'h04;
  localparam logic [7:0]  REG_RAILS      = 8'h08;
  localparam logic [7:0]  REG_MONITOR    = 8'h0c;
  // reset values
  localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
  // axi responses
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
  // power states
  typedef enum logic [1:0] {
    APSQ_ACTIVE,
    APSQ_S3,
    APSQ_S5
  } apsq_pstate_e;
endpackage : apsq_pkg
`default_nettype wire

// ==== hw/apsq_deglitch.sv ====
// glitch filter for one active-low sleep request input
`default_nettype none
module apsq_deglitch
  import apsq_pkg::*;
(
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic ce,
  // raw and filtered level
  input  wire logic din,
  output logic      dout
);
  logic [CNT_W-1:0] cnt_ff;   // cycles the input has differed
  logic [CNT_W-1:0] nxt_cnt;
  logic             lvl_ff;   // accepted level
  logic             nxt_lvl;

  assign dout = lvl_ff;

  // accept a new level only after it holds the whole window
  always_comb
  begin
    nxt_cnt = '0;
    nxt_lvl = lvl_ff;
    if (din != lvl_ff)
    begin
      if (cnt_ff >= CNT_W'(GLITCH_CYC - 1))
        nxt_lvl = din;
      else
        nxt_cnt = cnt_ff + 1'b1;
    end
  end

  // registers; pull-ups make the idle level high
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_ff <= '0;
      lvl_ff <= 1'b1;
    end
    else if (ce)
    begin
      cnt_ff <= nxt_cnt;
      lvl_ff <= nxt_lvl;
    end
  end
endmodule : apsq_deglitch
`default_nettype wire

// ==== hw/apsq_axil.sv ====
// axi4-lite slave holding the control word and reading back the status words
`default_nettype none
module apsq_axil
  import apsq_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // write address and data
  input  wire logic [7:0]  s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  // read address and data
  input  wire logic [7:0]  s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  // block side
  output logic [31:0]      ctrl,
  input  wire logic [31:0] status,
  input  wire logic [31:0] rails,
  input  wire logic [31:0] monitor
);
  logic        aw_ff, nxt_aw;       // address captured
  logic        w_ff, nxt_w;         // data captured
  logic [7:0]  awa_ff, nxt_awa;
  logic [31:0] wd_ff, nxt_wd;
  logic [3:0]  ws_ff, nxt_ws;
  logic        bv_ff, nxt_bv;
  logic [1:0]  br_ff, nxt_br;
  logic        rv_ff, nxt_rv;
  logic [1:0]  rr_ff, nxt_rr;
  logic [31:0] rd_ff, nxt_rd;
  logic [31:0] ctrl_ff, nxt_ctrl;

  assign s_awready = !aw_ff && !bv_ff;
  assign s_wready  = !w_ff && !bv_ff;
  assign s_arready = !rv_ff;
  assign s_bvalid  = bv_ff;
  assign s_bresp   = br_ff;
  assign s_rvalid  = rv_ff;
  assign s_rresp   = rr_ff;
  assign s_rdata   = rd_ff;
  assign ctrl      = ctrl_ff;

  // write path takes address and data in either order
  always_comb
  begin
    nxt_aw   = aw_ff;
    nxt_w    = w_ff;
    nxt_awa  = awa_ff;
    nxt_wd   = wd_ff;
    nxt_ws   = ws_ff;
    nxt_bv   = bv_ff;
    nxt_br   = br_ff;
    nxt_ctrl = ctrl_ff;
    if (s_awvalid && s_awready)
    begin
      nxt_aw  = 1'b1;
      nxt_awa = s_awaddr;
    end
    if (s_wvalid && s_wready)
    begin
      nxt_w  = 1'b1;
      nxt_wd = s_wdata;
      nxt_ws = s_wstrb;
    end
    if (aw_ff && w_ff)
    begin
      nxt_aw = 1'b0;
      nxt_w  = 1'b0;
      nxt_bv = 1'b1;
      nxt_br = RESP_OKAY;
      if (awa_ff[7:2] == REG_CTRL[7:2])
      begin
        for (int i = 0; i < 4; i++)
          if (ws_ff[i])
            nxt_ctrl[i*8 +: 8] = wd_ff[i*8 +: 8];
      end
      else if (awa_ff[7:2] != REG_STATUS[7:2] &&
               awa_ff[7:2] != REG_RAILS[7:2] &&
               awa_ff[7:2] != REG_MONITOR[7:2])
        nxt_br = RESP_SLVERR;           // unmapped address
    end
    if (bv_ff && s_bready)
      nxt_bv = 1'b0;
  end

  // read path answers one cycle after the address
  always_comb
  begin
    nxt_rv = rv_ff;
    nxt_rr = rr_ff;
    nxt_rd = rd_ff;
    if (s_arvalid && s_arready)
    begin
      nxt_rv = 1'b1;
      nxt_rr = RESP_OKAY;
      case (s_araddr[7:2])
        REG_CTRL[7:2]:    nxt_rd = ctrl_ff;
        REG_STATUS[7:2]:  nxt_rd = status;
        REG_RAILS[7:2]:   nxt_rd = rails;
        REG_MONITOR[7:2]: nxt_rd = monitor;
        default:
        begin
          nxt_rd = 32'h0000_0000;
          nxt_rr = RESP_SLVERR;
        end
      endcase
    end
    else if (rv_ff && s_rready)
      nxt_rv = 1'b0;
  end

  // registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_ff   <= 1'b0;
      w_ff    <= 1'b0;
      awa_ff  <= 8'h00;
      wd_ff   <= 32'h0000_0000;
      ws_ff   <= 4'h0;
      bv_ff   <= 1'b0;
      br_ff   <= RESP_OKAY;
      rv_ff   <= 1'b0;
      rr_ff   <= RESP_OKAY;
      rd_ff   <= 32'h0000_0000;
      ctrl_ff <= CTRL_RESET;
    end
    else if (ce)
    begin
      aw_ff   <= nxt_aw;
      w_ff    <= nxt_w;
      awa_ff  <= nxt_awa;
      wd_ff   <= nxt_wd;
      ws_ff   <= nxt_ws;
      bv_ff   <= nxt_bv;
      br_ff   <= nxt_br;
      rv_ff   <= nxt_rv;
      rr_ff   <= nxt_rr;
      rd_ff   <= nxt_rd;
      ctrl_ff <= nxt_ctrl;
    end
  end
endmodule : apsq_axil
`default_nettype wire

// ==== hw/apsq_top.sv ====
// sleep-state power sequencer: decode, timers, rail enables, registers
`default_nettype none
module apsq_top
  import apsq_pkg::*;
#(
  parameter int unsigned WAKE_CYCLES   = WAKE_CYC,
  parameter int unsigned SLEEP_CYCLES  = SLEEP_DLY_CYC,
  parameter int unsigned VID_RAIL_GOOD_CYCLES = VID_RAIL_GOOD_CYC
)
(
  // clock, reset, enable
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // sleep requests and straps
  input  wire logic        sleep3_request_n,
  input  wire logic        soft_off_request_n,
  input  wire logic        dual5_keep_in_off,
  input  wire logic        network_rail_mode,
  // supply and rail monitors, high when above threshold; soft_start_low is high when its pin is low
  input  wire logic        main3v3_good,
  input  wire logic        main5v_good,
  input  wire logic        standby_por_ok,
  input  wire logic        dual3v3_rail_ok,
  input  wire logic        dual5_rail_ok,
  input  wire logic        network_rail_feedback_ok,
  input  wire logic        vid_rail_ok,
  input  wire logic        over_temp,
  input  wire logic        soft_start_low,
  // rail controls
  output logic             dual3v3_standby_drive,
  output logic             dual3v3_uv_enable,
  output logic             active_switch_gate,
  output logic             active_switch_gate_oe,
  output logic             dual5_standby_gate,
  output logic             vid_rail_enable,
  output logic             vid_rail_good,
  output logic             vid_rail_good_oe,
  output logic             network_rail_gate_drive,
  output logic             rail_uv_enable,
  output logic             fault,
  // axi4-lite slave
  input  wire logic [7:0]  s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  input  wire logic [7:0]  s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready
);
  ////////////////////////////////////////////////////////////////////////
  // declarations
  logic [1:0]       req_raw;      // {soft_off, sleep3} raw
  logic [1:0]       req_f;        // filtered requests
  logic [31:0]      ctrl;         // software control word
  logic             sw_off;       // software forces all rails off
  logic             sw_fault_mask;// software hides fault output
  apsq_pstate_e     st_ff, nxt_st;       // decoded power state
  logic             sup_fall_ff, nxt_sup_fall; // forced s5 by supply loss
  logic             up_ff, nxt_up;       // active outputs released
  logic             por_ff, nxt_por;     // standby soft-start done
  logic             slp_pend_ff, nxt_slp_pend; // sleep delay running
  logic             s3_prev_ff, nxt_s3_prev;   // last filtered sleep3
  logic [CNT_W-1:0] slp_cnt_ff, nxt_slp_cnt;
  logic [CNT_W-1:0] wake_cnt_ff, nxt_wake_cnt;
  logic [CNT_W-1:0] por_cnt_ff, nxt_por_cnt;
  logic [CNT_W-1:0] pg_cnt_ff, nxt_pg_cnt;
  logic             pg_ff, nxt_pg;       // vid good released
  logic             fault_ff, nxt_fault; // registered fault
  logic             uv_seen_ff, nxt_uv_seen; // sticky uv record
  logic             mains_ok;
  logic             run;          // outputs allowed at all
  logic             is_active;
  logic             any_uv;

  assign req_raw       = {soft_off_request_n, sleep3_request_n};
  assign sw_off        = ctrl[0];
  assign sw_fault_mask = ctrl[1];
  assign mains_ok      = main3v3_good && main5v_good;
  // soft-start pin low or software off stops every rail output and fault; decode keeps running
  assign run           = por_ff && !soft_start_low && !sw_off;
  assign is_active     = (st_ff == APSQ_ACTIVE) && up_ff;

  ////////////////////////////////////////////////////////////////////////
  // input filters, one per request line
  for (genvar g = 0; g < 2; g++)
  begin : g_filt
    apsq_deglitch u_dg
    (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ce      (ce),
      .din     (req_raw[g]),
      .dout    (req_f[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // standby power-on reset pause before soft-start
  always_comb
  begin
    nxt_por     = por_ff;
    nxt_por_cnt = por_cnt_ff;
    if (!standby_por_ok)
    begin
      nxt_por     = 1'b0;
      nxt_por_cnt = '0;
    end
    else if (!por_ff)
    begin
      if (por_cnt_ff >= CNT_W'(POR_DLY_CYC - 1))
        nxt_por = 1'b1;
      else
        nxt_por_cnt = por_cnt_ff + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state decode, sleep delay and supply fallback
  // the timers count aclk cycles with ce high; lengths come from the rate
  always_comb
  begin
    nxt_st       = st_ff;
    nxt_sup_fall = sup_fall_ff;
    nxt_slp_pend = slp_pend_ff;
    nxt_slp_cnt  = slp_cnt_ff;
    nxt_s3_prev  = req_f[0];
    if (st_ff == APSQ_ACTIVE && !mains_ok)
    begin
      nxt_st       = APSQ_S5;
      nxt_sup_fall = 1'b1;
      nxt_slp_pend = 1'b0;
    end
    else if (sup_fall_ff)
    begin
      // leave forced s5 only when mains return and host wants active
      if (mains_ok && req_f == 2'b11)
      begin
        nxt_st       = APSQ_ACTIVE;
        nxt_sup_fall = 1'b0;
      end
    end
    else
    begin
      // falling sleep3 arms the 200 us timer
      if (s3_prev_ff && !req_f[0] && st_ff == APSQ_ACTIVE)
      begin
        nxt_slp_pend = 1'b1;
        nxt_slp_cnt  = '0;
      end
      else if (slp_pend_ff)
      begin
        if (req_f[0])
          nxt_slp_pend = 1'b0;        // request withdrawn
        else if (slp_cnt_ff >= CNT_W'(SLEEP_CYCLES - 1))
        begin
          nxt_slp_pend = 1'b0;
          nxt_st = req_f[1] ? APSQ_S3 : APSQ_S5;
        end
        else
          nxt_slp_cnt = slp_cnt_ff + 1'b1;
      end
      else
      begin
        case (req_f)
          2'b11:   nxt_st = APSQ_ACTIVE;
          2'b00:   if (st_ff == APSQ_S3)
                     nxt_st = APSQ_S5;
          // s3 request while in s5 is blocked
          2'b10:   nxt_st = st_ff;
          default: nxt_st = st_ff;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // wake timeout: mains must hold good 50 ms before active rails
  always_comb
  begin
    nxt_up       = up_ff;
    nxt_wake_cnt = wake_cnt_ff;
    if (st_ff != APSQ_ACTIVE || !mains_ok || !run)
    begin
      nxt_up       = 1'b0;
      nxt_wake_cnt = '0;
    end
    else if (!up_ff)
    begin
      if (wake_cnt_ff >= CNT_W'(WAKE_CYCLES - 1))
        nxt_up = 1'b1;
      else
        nxt_wake_cnt = wake_cnt_ff + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // vid power-good delay
  always_comb
  begin
    nxt_pg     = pg_ff;
    nxt_pg_cnt = pg_cnt_ff;
    if (!vid_rail_ok || !vid_rail_enable)
    begin
      nxt_pg     = 1'b0;
      nxt_pg_cnt = '0;
    end
    else if (!pg_ff)
    begin
      if (pg_cnt_ff >= CNT_W'(VID_RAIL_GOOD_CYCLES - 1))
        nxt_pg = 1'b1;
      else
        nxt_pg_cnt = pg_cnt_ff + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // fault: undervoltage on monitored rails, inputs, or heat
  always_comb
  begin
    any_uv = (!dual3v3_rail_ok)
           || (dual5_standby_gate && !dual5_rail_ok)
           || (network_rail_gate_drive && !network_rail_feedback_ok)
           || (vid_rail_enable && !vid_rail_ok);
    nxt_fault = (any_uv || !mains_ok || over_temp) && run;
    // sticky record: a new event wins over a software clear
    nxt_uv_seen = (uv_seen_ff && !ctrl[2]) || any_uv;
  end

  ////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_ff       <= APSQ_S5;
      sup_fall_ff <= 1'b0;
      up_ff       <= 1'b0;
      por_ff      <= 1'b0;
      slp_pend_ff <= 1'b0;
      s3_prev_ff  <= 1'b1;
      slp_cnt_ff  <= '0;
      wake_cnt_ff <= '0;
      por_cnt_ff  <= '0;
      pg_cnt_ff   <= '0;
      pg_ff       <= 1'b0;
      fault_ff    <= 1'b0;
      uv_seen_ff  <= 1'b0;
    end
    else if (ce)
    begin
      st_ff       <= nxt_st;
      sup_fall_ff <= nxt_sup_fall;
      up_ff       <= nxt_up;
      por_ff      <= nxt_por;
      slp_pend_ff <= nxt_slp_pend;
      s3_prev_ff  <= nxt_s3_prev;
      slp_cnt_ff  <= nxt_slp_cnt;
      wake_cnt_ff <= nxt_wake_cnt;
      por_cnt_ff  <= nxt_por_cnt;
      pg_cnt_ff   <= nxt_pg_cnt;
      pg_ff       <= nxt_pg;
      fault_ff    <= nxt_fault;
      uv_seen_ff  <= nxt_uv_seen;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // rail outputs; active switch gate and vid good pins are open-collector: oe high pulls low
  assign dual3v3_standby_drive   = run && !is_active;
  assign dual3v3_uv_enable       = run;
  assign active_switch_gate      = 1'b0;
  assign active_switch_gate_oe   = !(run && is_active);
  assign dual5_standby_gate      = run && (st_ff == APSQ_S3 ||
                                   (st_ff == APSQ_S5 && dual5_keep_in_off)
                                   || (st_ff == APSQ_ACTIVE && !up_ff));
  assign vid_rail_enable         = run && is_active;
  assign vid_rail_good           = 1'b0;
  assign vid_rail_good_oe        = !pg_ff;
  assign network_rail_gate_drive = run && (is_active ||
                                   network_rail_mode);
  assign rail_uv_enable          = run;
  assign fault                   = fault_ff && !sw_fault_mask;

  ////////////////////////////////////////////////////////////////////////
  // register slave
  apsq_axil u_regs
  (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .ce        (ce),
    .s_awaddr  (s_awaddr),
    .s_awvalid (s_awvalid),
    .s_awready (s_awready),
    .s_wdata   (s_wdata),
    .s_wstrb   (s_wstrb),
    .s_wvalid  (s_wvalid),
    .s_wready  (s_wready),
    .s_bresp   (s_bresp),
    .s_bvalid  (s_bvalid),
    .s_bready  (s_bready),
    .s_araddr  (s_araddr),
    .s_arvalid (s_arvalid),
    .s_arready (s_arready),
    .s_rdata   (s_rdata),
    .s_rresp   (s_rresp),
    .s_rvalid  (s_rvalid),
    .s_rready  (s_rready),
    .ctrl      (ctrl),
    .status    ({24'h00_0000, uv_seen_ff, fault_ff, pg_ff, up_ff,
                 sup_fall_ff, por_ff, st_ff}),
    .rails     ({26'h000_0000, network_rail_gate_drive, vid_rail_enable,
                 dual5_standby_gate, !active_switch_gate_oe,
                 dual3v3_standby_drive, run}),
    .monitor   ({24'h00_0000, over_temp, vid_rail_ok,
                 network_rail_feedback_ok, dual5_rail_ok, dual3v3_rail_ok,
                 main5v_good, main3v3_good, req_f[1] & req_f[0]})
  );
endmodule : apsq_top
`default_nettype wire

// ==== dv/apsq_props.sv ====
// checker of port-level sequencing rules for the power sequencer
`default_nettype none
module apsq_props #(
  parameter int unsigned VID_RAIL_GOOD_CYCLES = 10
)
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // monitors
  input wire logic main5v_good,
  input wire logic vid_rail_ok,
  input wire logic over_temp,
  input wire logic soft_start_low,
  // rail controls
  input wire logic dual3v3_standby_drive,
  input wire logic active_switch_gate,
  input wire logic active_switch_gate_oe,
  input wire logic vid_rail_enable,
  input wire logic vid_rail_good_oe,
  input wire logic dual5_standby_gate,
  input wire logic network_rail_gate_drive,
  input wire logic fault
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // run length of the vid good level, saturating so it never wraps
  logic [7:0] ok_cnt_ff;
  logic [7:0] nxt_ok_cnt;
  always_comb
  begin
    nxt_ok_cnt = ok_cnt_ff + 8'h01;
    if (!vid_rail_ok)
      nxt_ok_cnt = 8'h00;
    else if (ok_cnt_ff == 8'hff)
      nxt_ok_cnt = ok_cnt_ff;
  end
  always_ff @(posedge aclk)
    ok_cnt_ff <= aresetn ? nxt_ok_cnt : 8'h00;
  ////////////////////////////////////////////////////////////////////////////
  property p_gate_low;
    active_switch_gate == 1'h0;
  endproperty
  a_gate_low: assert property (p_gate_low)
    else $error("active switch output driven high");
  property p_std_drive;
    dual3v3_standby_drive && $past(dual3v3_standby_drive)
      |-> $past(active_switch_gate_oe);
  endproperty
  a_std_drive: assert property (p_std_drive)
    else $error("standby drive on while main switch released");
  property p_vid_en;
    vid_rail_enable && $past(vid_rail_enable)
      |-> !$past(active_switch_gate_oe);
  endproperty
  a_vid_en: assert property (p_vid_en)
    else $error("vid regulator on outside the active state");
  property p_drop;
    $fell(main5v_good) |-> ##[1:4] active_switch_gate_oe && !vid_rail_enable;
  endproperty
  a_drop: assert property (p_drop)
    else $error("no fallback after main supply loss");
  property p_kill;
    soft_start_low [*3] |-> !fault && !vid_rail_enable &&
      !network_rail_gate_drive && !dual5_standby_gate;
  endproperty
  a_kill: assert property (p_kill)
    else $error("outputs alive with soft-start node low");
  property p_hot;
    (over_temp && !soft_start_low) [*4] |-> fault;
  endproperty
  a_hot: assert property (p_hot)
    else $error("no fault on overtemperature");
  property p_vid_rail_good;
    $fell(vid_rail_good_oe) |-> ok_cnt_ff >= VID_RAIL_GOOD_CYCLES - 1;
  endproperty
  a_vid_rail_good: assert property (p_vid_rail_good)
    else $error("vid good released before its delay");
  property p_vid_low;
    !vid_rail_ok |-> ##[0:3] vid_rail_good_oe;
  endproperty
  a_vid_low: assert property (p_vid_low)
    else $error("vid good not held low with rail low");
  // main scenarios reached
  c_wake: cover property ($fell(active_switch_gate_oe));
  c_drop: cover property ($fell(main5v_good));
  c_pg: cover property ($fell(vid_rail_good_oe));
endmodule : apsq_props
`default_nettype wire

// ==== dv/apsq_chipset.sv ====
// model of the chipset sleep lines and the main supply monitors
`default_nettype none
module apsq_chipset (
  // clock
  input wire logic aclk,
  // sleep requests, active low
  output var logic sleep3_request_n,
  output var logic soft_off_request_n,
  // main supply monitors, high when good
  output var logic main3v3_good,
  output var logic main5v_good
);
  timeunit 1ns;
  timeprecision 1ns;
  // soft off requested, mains down at power-up
  initial {soft_off_request_n, sleep3_request_n} = 2'h0;
  initial {main3v3_good, main5v_good} = 2'h0;
  // both request lines move together just after an edge
  task automatic req(input logic s5n, input logic s3n);
    @(posedge aclk);
    soft_off_request_n <= s5n;
    sleep3_request_n <= s3n;
  endtask : req
  // each supply may fail on its own
  task automatic mains(input logic ok3, input logic ok5);
    @(posedge aclk);
    main3v3_good <= ok3;
    main5v_good <= ok5;
  endtask : mains
endmodule : apsq_chipset
`default_nettype wire

// ==== dv/apsq_top_tb.sv ====
// self-checking bench for the sleep-state power sequencer
`default_nettype none
module apsq_top_tb
  import apsq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // bench-held inputs
  logic aclk = 1'h0, aresetn = 1'h0, ce = 1'h1;
  logic dual5_keep_in_off = 1'h0, network_rail_mode = 1'h0;
  logic standby_por_ok = 1'h0, over_temp = 1'h0, soft_start_low = 1'h0;
  logic dual3v3_rail_ok = 1'h1, dual5_rail_ok = 1'h1;
  logic network_rail_feedback_ok = 1'h1, vid_rail_ok = 1'h0;
  logic sleep3_request_n, soft_off_request_n, main3v3_good, main5v_good;
  // rail controls
  logic dual3v3_standby_drive, dual3v3_uv_enable, active_switch_gate;
  logic active_switch_gate_oe, dual5_standby_gate, vid_rail_enable;
  logic vid_rail_good, vid_rail_good_oe, network_rail_gate_drive;
  logic rail_uv_enable, fault;
  // register bus
  logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00;
  logic [31:0] s_wdata = 32'h0, s_rdata, d;
  logic [3:0] s_wstrb = 4'hf;
  logic s_awvalid = 1'h0, s_wvalid = 1'h0, s_bready = 1'h0;
  logic s_arvalid = 1'h0, s_rready = 1'h0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0] s_bresp, s_rresp, r;
  int n_fail = 0, total_checks = 0;
  apsq_chipset pm (.*);
  apsq_top #(.WAKE_CYCLES(50), .SLEEP_CYCLES(20), .VID_RAIL_GOOD_CYCLES(10))
    dut_u (.*);
  initial forever #25 aclk = ~aclk;
  // the vid rail comes up one cycle after its regulator is enabled
  always @(posedge aclk) vid_rail_ok <= vid_rail_enable;
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc
  // a bus wait that runs out ends the run as a failure
  task automatic tmo;
    n_fail++;
    end_of_test();
  endtask : tmo
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_awaddr <= a;
    s_wdata <= v;
    s_awvalid <= 1'h1;
    s_wvalid <= 1'h1;
    s_bready <= 1'h1;
    for (int i = 0; i < 100; i++)
    begin
      @(posedge aclk);
      if (s_awvalid && s_awready) s_awvalid <= 1'h0;
      if (s_wvalid && s_wready) s_wvalid <= 1'h0;
      if (!s_awvalid && !s_wvalid && s_bvalid)
      begin
        r = s_bresp;
        s_bready <= 1'h0;
        return;
      end
    end
    tmo();
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1'h1;
    s_rready <= 1'h1;
    for (int i = 0; i < 100; i++)
    begin
      @(posedge aclk);
      if (s_arvalid && s_arready) s_arvalid <= 1'h0;
      if (!s_arvalid && s_rvalid)
      begin
        d = s_rdata;
        r = s_rresp;
        s_rready <= 1'h0;
        return;
      end
    end
    tmo();
  endtask : rd
  // state from status, then pins: std drive, gate oe, 5v gate, net, vid
  task automatic look(input logic [1:0] s, input logic [4:0] p);
    rd(REG_STATUS);
    check(d[1:0], s);
    @(negedge aclk);
    check({dual3v3_standby_drive, active_switch_gate_oe,
      dual5_standby_gate, network_rail_gate_drive, vid_rail_enable}, p);
  endtask : look
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    cyc(12);
    aresetn <= 1'h1;
    standby_por_ok <= 1'h1;
    cyc(300);
    rd(REG_CTRL);
    check(d, CTRL_RESET);
    look(2'h2, 5'h18);
    check(dual3v3_uv_enable, 1'h1);
    check({rail_uv_enable, vid_rail_good}, 2'h2);
    pm.mains(1'h1, 1'h1);
    pm.req(1'h1, 1'h0);
    cyc(100);
    look(2'h2, 5'h18);
    pm.req(1'h1, 1'h1);
    cyc(19);
    pm.req(1'h1, 1'h0);
    cyc(100);
    look(2'h2, 5'h18);
    pm.req(1'h1, 1'h1);
    cyc(70);
    look(2'h0, 5'h1c);
    cyc(60);
    look(2'h0, 5'h03);
    cyc(20);
    check(vid_rail_good_oe, 1'h0);
    pm.req(1'h1, 1'h0);
    cyc(45);
    look(2'h0, 5'h03);
    cyc(40);
    look(2'h1, 5'h1c);
    pm.req(1'h0, 1'h0);
    cyc(100);
    look(2'h2, 5'h18);
    // s3 request from plain s5 (no supply fallback) must be refused
    pm.req(1'h1, 1'h0);
    cyc(100);
    look(2'h2, 5'h18);
    cyc(1);
    dual5_keep_in_off <= 1'h1;
    network_rail_mode <= 1'h1;
    pm.req(1'h0, 1'h1);
    cyc(100);
    look(2'h2, 5'h1e);
    pm.req(1'h1, 1'h1);
    cyc(150);
    look(2'h0, 5'h03);
    pm.mains(1'h1, 1'h0);
    cyc(10);
    look(2'h2, 5'h1e);
    check(d[3], 1'h1);
    pm.mains(1'h1, 1'h1);
    cyc(150);
    look(2'h0, 5'h03);
    cyc(1);
    over_temp <= 1'h1;
    cyc(6);
    check(fault, 1'h1);
    soft_start_low <= 1'h1;
    cyc(6);
    check({fault, vid_rail_enable}, 2'h0);
    soft_start_low <= 1'h0;
    over_temp <= 1'h0;
    rd(8'h10);
    check(d, 32'h0000_0000);
    check(r, RESP_SLVERR);
    wr(8'h10, 32'h0000_0001);
    check(r, RESP_SLVERR);
    // software off: every rail drops while the decoded state is kept
    wr(REG_CTRL, 32'h0000_0001);
    check(r, RESP_OKAY);
    rd(REG_CTRL);
    check(d, 32'h0000_0001);
    look(2'h0, 5'h08);
    wr(REG_CTRL, CTRL_RESET);
    check(r, RESP_OKAY);
    end_of_test();
  end
endmodule : apsq_top_tb
bind apsq_top apsq_props #(.VID_RAIL_GOOD_CYCLES(VID_RAIL_GOOD_CYCLES)) u_props (.*);
`default_nettype wire
